// >>> rtl/hcpm_top.sv
`timescale 1ns/1ps
// ==========================================================
// control pin function mux for the host port
module hcpm_top (
  input  wire logic                          clk,
  input  wire logic                          nrst,
  input  wire logic                          ce,
  input  wire logic                          port_function_strap,
  input  wire logic                          host_ctrl_pin_first_i,
  output logic                               host_ctrl_pin_first_o,
  output logic                               host_ctrl_pin_first_oe,
  input  wire logic                          host_ctrl_pin_second_i,
  output logic                               host_ctrl_pin_second_o,
  output logic                               host_ctrl_pin_second_oe,
  input  wire logic [hcpm_pkg::HCPM_BYTE_W-1:0] host_data_i,
  input  wire logic [1:0]                    gpio_dir,
  input  wire logic [1:0]                    gpio_out,
  output logic      [1:0]                    gpio_in,
  output logic                               host_mux_mode,
  output logic      [hcpm_pkg::HCPM_ADDR_W-1:0] host_address_register,
  output logic                               host_addr_valid
);

  // ==========================================================
  // strap capture
  logic               boot_reg;
  logic               boot_next;
  logic               fn_valid_reg;
  logic               fn_valid_next;
  hcpm_pkg::hcpm_fn_t fn_reg;
  hcpm_pkg::hcpm_fn_t fn_next;
  logic               strap_s;

  // strap is an async pin, so it goes through the synchroniser too;
  // this one is never reset, so it keeps sampling while reset is low and
  // shows the strap level held during reset at the first edge after release
  hcpm_sync u_strap_sync (
    .clk  (clk),
    .nrst (1'b1),
    .ce   (ce),
    .din  (port_function_strap),
    .dout (strap_s)
  );

  // catch the strap on the first enabled edge after release; a 4-cycle
  // pipeline lag (three stages plus the output register) means the strap must be steady in the cycles before the release
  always_comb begin
    boot_next     = boot_reg;
    fn_valid_next = fn_valid_reg;
    fn_next       = fn_reg;
    if (ce && !boot_reg) begin
      boot_next     = 1'b1;
      fn_valid_next = 1'b1;
      fn_next       = strap_s ? hcpm_pkg::HCPM_FN_HOST
                              : hcpm_pkg::HCPM_FN_GPIO;
    end
  end

  // held until the next reset; later strap changes ignored
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      boot_reg     <= 1'b0;
      fn_valid_reg <= 1'b0;
      fn_reg       <= hcpm_pkg::HCPM_FN_GPIO;
    end else begin
      boot_reg     <= boot_next;
      fn_valid_reg <= fn_valid_next;
      fn_reg       <= fn_next;
    end
  end

  logic mux_on;
  logic mux_next;
  assign mux_on        = fn_valid_reg && (fn_reg == hcpm_pkg::HCPM_FN_HOST);
  assign mux_next      = fn_valid_next && (fn_next == hcpm_pkg::HCPM_FN_HOST);
  assign host_mux_mode = mux_on;

  // ==========================================================
  // pin synchronisers, one per control pin
  logic [1:0] pin_raw;
  logic [1:0] pin_s;
  assign pin_raw = {host_ctrl_pin_second_i, host_ctrl_pin_first_i};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      hcpm_sync u_pin_sync (
        .clk  (clk),
        .nrst (nrst),
        .ce   (ce),
        .din  (pin_raw[g]),
        .dout (pin_s[g])
      );
    end
  endgenerate

  // ==========================================================
  // general-purpose side; drivers only in gpio mode and only if set out
  logic [1:0] oe_reg;
  logic [1:0] oe_next;
  logic [1:0] do_reg;
  logic [1:0] do_next;
  logic [1:0] gi_reg;
  logic [1:0] gi_next;

  always_comb begin
    oe_next = oe_reg;
    do_next = do_reg;
    gi_next = gi_reg;
    if (ce) begin
      // host mode keeps both pins inputs to the device
      oe_next = (fn_valid_reg && !mux_on) ? gpio_dir : 2'h0;
      do_next = gpio_out;
      // next mode, so gpio_in is already quiet when host mode shows
      gi_next = mux_next ? 2'h0 : pin_s;
    end
  end

  // reset leaves both bits inputs with drivers off
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oe_reg <= {2{hcpm_pkg::HCPM_DIR_RST}};
      do_reg <= {2{hcpm_pkg::HCPM_BIT_RST}};
      gi_reg <= 2'h0;
    end else begin
      oe_reg <= oe_next;
      do_reg <= do_next;
      gi_reg <= gi_next;
    end
  end

  assign host_ctrl_pin_first_o   = do_reg[0];
  assign host_ctrl_pin_first_oe  = oe_reg[0];
  assign host_ctrl_pin_second_o  = do_reg[1];
  assign host_ctrl_pin_second_oe = oe_reg[1];
  assign gpio_in                 = gi_reg;

  // ==========================================================
  // address capture on the strobe; data bus is sampled with the strobe
  // through three stages so data and strobe stay aligned
  logic [hcpm_pkg::HCPM_BYTE_W-1:0] d1_reg, d2_reg, d3_reg;
  logic [hcpm_pkg::HCPM_BYTE_W-1:0] d1_next, d2_next, d3_next;
  logic                             strobe_d_reg;
  logic                             strobe_d_next;
  logic [hcpm_pkg::HCPM_ADDR_W-1:0] addr_reg;
  logic [hcpm_pkg::HCPM_ADDR_W-1:0] addr_next;
  logic                             av_reg;
  logic                             av_next;
  hcpm_pkg::hcpm_state_t            st_reg;
  hcpm_pkg::hcpm_state_t            st_next;
  logic                             strobe_fall;

  // strobe is active low; its falling edge latches the byte
  assign strobe_fall = strobe_d_reg && !pin_s[0];

  always_comb begin
    d1_next       = d1_reg;
    d2_next       = d2_reg;
    d3_next       = d3_reg;
    strobe_d_next = strobe_d_reg;
    addr_next     = addr_reg;
    av_next       = 1'b0;
    st_next       = st_reg;
    if (ce) begin
      d1_next       = host_data_i;
      d2_next       = d1_reg;
      d3_next       = d2_reg;
      strobe_d_next = pin_s[0];
      case (st_reg)
        hcpm_pkg::HCPM_ST_LATCH: begin
          if (mux_on) begin
            st_next = hcpm_pkg::HCPM_ST_ARMED;
          end
        end
        hcpm_pkg::HCPM_ST_ARMED: begin
          if (mux_on && strobe_fall) begin
            // byte select low marks first byte (high half)
            if (!pin_s[1]) begin
              addr_next[hcpm_pkg::HCPM_ADDR_W-1:hcpm_pkg::HCPM_BYTE_W] = d3_reg;
            end else begin
              addr_next[hcpm_pkg::HCPM_BYTE_W-1:0] = d3_reg;
              av_next = 1'b1;
            end
          end
        end
        default: begin
          st_next = hcpm_pkg::HCPM_ST_LATCH;
        end
      endcase
    end else begin
      av_next = av_reg;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      d1_reg       <= '0;
      d2_reg       <= '0;
      d3_reg       <= '0;
      strobe_d_reg <= 1'b1;
      addr_reg     <= '0;
      av_reg       <= 1'b0;
      st_reg       <= hcpm_pkg::HCPM_ST_LATCH;
    end else begin
      d1_reg       <= d1_next;
      d2_reg       <= d2_next;
      d3_reg       <= d3_next;
      strobe_d_reg <= strobe_d_next;
      addr_reg     <= addr_next;
      av_reg       <= av_next;
      st_reg       <= st_next;
    end
  end

  assign host_address_register = addr_reg;
  assign host_addr_valid       = av_reg;

endmodule

// >>> rtl/hcpm_pkg.sv
// Notes on behaviour
// - strap low in reset: first control pin becomes parallel I/O bit
// - strap high in reset: first control pin becomes host address strobe
// - function fixed when reset releases, then kept
// - strap low in reset: second control pin becomes parallel I/O bit
// - strap high in reset: second control pin becomes host byte select
// - first pin I/O bit comes up as input, driver off
// - address strobe is an input to the device
// - second pin I/O bit comes up as input, driver off
// - strobe pulse captures presented address into host address register
// - strobe honoured only in multiplexed mode, ignored otherwise
// - multiplexed host cycle is two back-to-back byte transfers on 8-bit bus
package hcpm_pkg;

  // ==========================================================
  // widths and reset values
  localparam int unsigned HCPM_BYTE_W   = 8;
  localparam int unsigned HCPM_ADDR_W   = 16;
  localparam int unsigned HCPM_SYNC_LEN = 3;
  localparam logic        HCPM_MUX_RST  = 1'b0;
  localparam logic        HCPM_DIR_RST  = 1'b0;
  localparam logic        HCPM_BIT_RST  = 1'b0;

  // pin function after the strap is caught
  typedef enum logic {
    HCPM_FN_GPIO,
    HCPM_FN_HOST
  } hcpm_fn_t;

  // capture of the host address bytes
  typedef enum logic [1:0] {
    HCPM_ST_LATCH,
    HCPM_ST_ARMED,
    HCPM_ST_DONE
  } hcpm_state_t;

endpackage

// >>> rtl/hcpm_sync.sv
`timescale 1ns/1ps
// ==========================================================
// three-stage pin synchroniser; stage 0 feeds only stage 1
module hcpm_sync (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ce,
  input  wire logic din,
  output logic      dout
);

  logic [hcpm_pkg::HCPM_SYNC_LEN-1:0] sh_reg;
  logic [hcpm_pkg::HCPM_SYNC_LEN-1:0] sh_next;
  logic                               out_reg;
  logic                               out_next;

  // shift in, accept a change once last two stages agree
  always_comb begin
    sh_next  = sh_reg;
    out_next = out_reg;
    if (ce) begin
      sh_next = {sh_reg[hcpm_pkg::HCPM_SYNC_LEN-2:0], din};
      if (sh_reg[1] == sh_reg[2]) begin
        out_next = sh_reg[2];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sh_reg  <= '0;
      out_reg <= 1'b0;
    end else begin
      sh_reg  <= sh_next;
      out_reg <= out_next;
    end
  end

  assign dout = out_reg;

endmodule

// >>> sim/hcpm_checker.sv
`timescale 1ns/1ps
// ==========================================
// port checker for the control pin mux
module hcpm_checker (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        ce,
  input wire logic        host_ctrl_pin_first_i,
  input wire logic        host_ctrl_pin_first_oe,
  input wire logic        host_ctrl_pin_second_i,
  input wire logic        host_ctrl_pin_second_oe,
  input wire logic [1:0]  gpio_dir,
  input wire logic [1:0]  gpio_in,
  input wire logic        host_mux_mode,
  input wire logic [15:0] host_address_register,
  input wire logic        host_addr_valid
);
  logic [1:0] rel_cnt_reg;
  logic [1:0] rel_cnt_next;
  // edges since release, saturating; the mode settles by edge 2
  always_comb begin
    rel_cnt_next = (ce && rel_cnt_reg != 2'h3) ? rel_cnt_reg + 2'h1 : rel_cnt_reg;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rel_cnt_reg <= 2'h0;
    end else begin
      rel_cnt_reg <= rel_cnt_next;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_first_fall;
    host_mux_mode && $fell(host_ctrl_pin_first_i) && !host_ctrl_pin_second_i;
  endsequence
  sequence s_second_fall;
    host_mux_mode && $fell(host_ctrl_pin_first_i) && host_ctrl_pin_second_i;
  endsequence
  a_host_oe_off: assert property (host_mux_mode |-> !host_ctrl_pin_first_oe && !host_ctrl_pin_second_oe) else $error("driver on in host mode");
  a_host_gpio_quiet: assert property (host_mux_mode |-> gpio_in == 2'h0) else $error("gpio input live in host mode");
  a_mode_held: assert property (rel_cnt_reg == 2'h3 |-> $stable(host_mux_mode)) else $error("pin function changed after reset");
  a_first_oe_dir: assert property (rel_cnt_reg == 2'h3 && !host_mux_mode && ce |=> host_ctrl_pin_first_oe == $past(gpio_dir[0])) else $error("first pin driver wrong");
  a_second_oe_dir: assert property (rel_cnt_reg == 2'h3 && !host_mux_mode && ce |=> host_ctrl_pin_second_oe == $past(gpio_dir[1])) else $error("second pin driver wrong");
  a_oe_off_release: assert property ($rose(nrst) |-> !host_ctrl_pin_first_oe && !host_ctrl_pin_second_oe) else $error("driver on at release");
  a_valid_host_only: assert property (host_addr_valid |-> host_mux_mode) else $error("capture outside host mode");
  a_gpio_addr_idle: assert property (!host_mux_mode && rel_cnt_reg == 2'h3 |-> host_address_register == 16'h0000) else $error("address moved in gpio mode");
  a_valid_single: assert property (host_addr_valid && ce |=> !host_addr_valid) else $error("valid longer than one cycle");
  a_second_capture: assert property (s_second_fall |-> ##[2:8] host_addr_valid) else $error("second byte not captured");
  a_first_no_valid: assert property (s_first_fall |-> ##1 !host_addr_valid [*6]) else $error("valid after first byte");
endmodule

bind hcpm_top hcpm_checker chk_u (.clk(clk), .nrst(nrst), .ce(ce),
  .host_ctrl_pin_first_i(host_ctrl_pin_first_i), .host_ctrl_pin_first_oe(host_ctrl_pin_first_oe),
  .host_ctrl_pin_second_i(host_ctrl_pin_second_i), .host_ctrl_pin_second_oe(host_ctrl_pin_second_oe),
  .gpio_dir(gpio_dir), .gpio_in(gpio_in), .host_mux_mode(host_mux_mode),
  .host_address_register(host_address_register), .host_addr_valid(host_addr_valid));

// >>> sim/hcpm_host_model.sv
`timescale 1ns/1ps
// ==========================================
// external host on the multiplexed port
module hcpm_host_model (
  input  wire logic       clk,
  output logic            strobe_n,
  output logic            bsel,
  output logic [7:0]      data
);
  initial begin
    strobe_n = 1'b1;
    bsel = 1'b0;
    data = 8'h00;
  end
  // one host cycle, high byte first; bus steady 3 cycles around each strobe
  task automatic send(input logic [15:0] a);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      data <= (i == 0) ? a[15:8] : a[7:0];
      bsel <= i[0];
      repeat (3) @(posedge clk);
      strobe_n <= 1'b0;
      repeat (3) @(posedge clk);
      strobe_n <= 1'b1;
      repeat (3) @(posedge clk);
    end
    // released bus shows the inverse so stale bytes cannot pass
    data <= ~data;
    bsel <= ~bsel;
  endtask
endmodule

// >>> sim/hcpm_top_tb.sv
`timescale 1ns/1ps
// ==========================================
// bench for the host control pin mux
module hcpm_top_tb;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        strap = 1'b0;
  logic [1:0]  dir = 2'h0;
  logic [1:0]  dout = 2'h0;
  logic        s_n, bsel, o0, oe0, o1, oe1, mode, valid;
  logic [7:0]  hd;
  logic [1:0]  din;
  logic [15:0] addr;
  int          n_fail = 0;
  int          n_checks = 0;
  int          cyc = 0;
  always #50 clk = ~clk;
  // pin level: device drive wins while its enable is high
  hcpm_top dut_u (.clk(clk), .nrst(nrst), .ce(1'b1), .port_function_strap(strap),
    .host_ctrl_pin_first_i(oe0 ? o0 : s_n), .host_ctrl_pin_first_o(o0),
    .host_ctrl_pin_first_oe(oe0), .host_ctrl_pin_second_i(oe1 ? o1 : bsel),
    .host_ctrl_pin_second_o(o1), .host_ctrl_pin_second_oe(oe1), .host_data_i(hd),
    .gpio_dir(dir), .gpio_out(dout), .gpio_in(din), .host_mux_mode(mode),
    .host_address_register(addr), .host_addr_valid(valid));
  hcpm_host_model p_u (.clk(clk), .strobe_n(s_n), .bsel(bsel), .data(hd));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // sample past the edge so registered outputs have landed
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic do_reset(input logic s);
    @(posedge clk);
    nrst <= 1'b0;
    strap <= s;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    wait_n(4);
  endtask
  task automatic t_gpio;
    do_reset(1'b0);
    chk("mode", {15'h0, mode}, 16'h0000);
    chk("oe", {14'h0, oe1, oe0}, 16'h0000);
    p_u.send(16'hA55A);
    wait_n(8);
    chk("addr", addr, 16'h0000);
    chk("gpio_in", {14'h0, din}, 16'h0001);
    @(posedge clk);
    dir <= 2'h3;
    dout <= 2'h2;
    wait_n(6);
    chk("oe", {14'h0, oe1, oe0}, 16'h0003);
    chk("gpio_in", {14'h0, din}, 16'h0002);
    @(posedge clk);
    dir <= 2'h0;
  endtask
  // strap dropped and core asks to drive: host mode must hold
  task automatic t_host;
    do_reset(1'b1);
    chk("mode", {15'h0, mode}, 16'h0001);
    @(posedge clk);
    strap <= 1'b0;
    dir <= 2'h3;
    p_u.send(16'h3CC3);
    wait_n(8);
    chk("addr", addr, 16'h3CC3);
    chk("oe", {14'h0, oe1, oe0}, 16'h0000);
    chk("mode", {15'h0, mode}, 16'h0001);
    p_u.send(16'hC30F);
    wait_n(8);
    chk("addr", addr, 16'hC30F);
    @(posedge clk);
    dir <= 2'h0;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_gpio;
    t_host;
    t_gpio;
    tally_and_finish;
  end
  // hang guard at 3000, far above the roughly 160 cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      tally_and_finish;
    end
  end
endmodule
